// [llr_ctrl.sv]
// LED level register control: serial level loading, pump mode, register bus
//
// Notes on behaviour
// [R1] Primary level is 8-bit, shared by all
// [R2] Primary level zero disables primary outputs
// [R3] Indicator level is a 2-bit code
// [R4] Indicator usable as serially set output
// [R5] Indicator never escalates pump mode
// [R6] Supply undervoltage forces registers to zero
// [R7] Two 4-bit camera levels, high and low
// [R8] Camera choice by serial port or pin
// [R9] Pin high selects high, low selects low
// [R10] Select pin falling edge returns pump 1x
// [R11] Camera level zero disables camera outputs
// [R12] One data bit per serial clock
// [R13] MSB first, sampled on rising clock
// [R14] Stop after write loads all levels together
// [R15] Dropouts step pump 1x, 1.5x, 2x
// [R16] Level update resets pump to 1x
// [R17] Power-up clears levels, pump at 1x
// [R18] Select pin synchronised and deglitched first
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "llr_defines.svh"

module llr_ctrl (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic UNDERVOLTAGE_LOCKOUT_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic CAM_SEL_I,
  input wire logic PRI_DROPOUT_I,
  input wire logic CAM_DROPOUT_I,
  output logic [7:0] PRI_LEVEL_O,
  output logic PRI_EN_O,
  output logic [3:0] CAM_LEVEL_O,
  output logic CAM_EN_O,
  output logic [1:0] AUX_LEVEL_O,
  output logic AUX_GPO_O,
  output logic AUX_GPO_MODE_O,
  output logic [1:0] PUMP_MODE_O,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // Whole block state and its next value
  llr_pkg::llr_state_t s_r;
  llr_pkg::llr_state_t s_nxt;

  // Serial line events
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic load_evt;

  // Camera choice, pin fall and dropout
  logic cam_use_hi;
  logic cam_fall;
  logic drop_now;
  logic [3:0] cam_sel_lvl;

  // Register readback words
  logic [31:0] status_word;
  logic [31:0] hold_word;

  // ----------------------------------------
  // Serial line events
  // ----------------------------------------
  assign start_cond = s_r.scl_d & SCL_I & s_r.sda_d & ~SDA_I;
  assign stop_cond = s_r.scl_d & SCL_I & ~s_r.sda_d & SDA_I;
  assign scl_rise = ~s_r.scl_d & SCL_I; // [R13]
  assign scl_fall = s_r.scl_d & ~SCL_I;
  assign load_evt = stop_cond & s_r.wrote; // [R14]

  // ----------------------------------------
  // Camera selection and dropout
  // ----------------------------------------
  // Serial override wins over the pin
  assign cam_use_hi = s_r.act_aux[`LLR_CAM_SER_OVR_BIT] ?
                      s_r.act_aux[`LLR_CAM_SER_SEL_BIT] : s_r.cam_filt; // [R8] [R9]
  assign cam_sel_lvl = cam_use_hi ? s_r.act_cam[7:4] : s_r.act_cam[3:0]; // [R7] [R9]
  assign cam_fall = s_r.cam_filt & ~s_r.cam_s2 &
                    (s_r.filt_cnt == 2'(`LLR_FILT_CYC)); // [R10]
  // Indicator has no dropout input at all
  assign drop_now = (PRI_DROPOUT_I & (s_r.act_pri != 8'h00)) |
                    (CAM_DROPOUT_I & (cam_sel_lvl != 4'h0)); // [R5] [R15]

  // Readback words, unused bits read zero
  assign status_word = {10'h000,
                        UNDERVOLTAGE_LOCKOUT_I, // Supply low
                        cam_use_hi, // High camera level in use
                        2'(s_r.pump), // Pump mode
                        s_r.act_aux[1:0], // Indicator level field
                        s_r.act_cam, // Both camera levels
                        s_r.act_pri}; // Primary level
  assign hold_word = {8'h00,
                      s_r.hold_aux, // Control byte
                      s_r.hold_cam, // Camera byte
                      s_r.hold_pri}; // Primary byte

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_d = SCL_I;
    s_nxt.sda_d = SDA_I;

    // ----------------------------------------
    // Serial receiver
    // ----------------------------------------
    // A start always restarts the address byte
    if (start_cond) begin
      s_nxt.ser_st = llr_pkg::SER_ADDR;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.byte_idx = 2'h0;
      s_nxt.pend_ack = 1'b0;
      s_nxt.in_ack = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      s_nxt.ser_st = llr_pkg::SER_IDLE;
      s_nxt.pend_ack = 1'b0;
      s_nxt.in_ack = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.wrote = 1'b0;
    end else begin
      if (scl_rise && !s_r.in_ack && !s_r.pend_ack) begin
        case (s_r.ser_st)
          llr_pkg::SER_ADDR,
          llr_pkg::SER_DATA: begin
            // One bit per clock, first bit lands at the top
            s_nxt.shreg = {s_r.shreg[6:0], SDA_I}; // [R12] [R13]
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7) begin
              // Address byte: own address and write bit earn an ack
              if (s_r.ser_st == llr_pkg::SER_ADDR) begin
                if ((s_r.shreg[6:0] == s_r.slave_addr) && !SDA_I) begin
                  s_nxt.ser_st = llr_pkg::SER_DATA;
                  s_nxt.pend_ack = 1'b1;
                end else begin
                  s_nxt.ser_st = llr_pkg::SER_SKIP;
                end
              end else begin
                // Data byte: always acked, even past the last register
                s_nxt.pend_ack = 1'b1;
                // Bytes land in holding registers only
                case (s_r.byte_idx)
                  2'h0: s_nxt.hold_pri = {s_r.shreg[6:0], SDA_I};
                  2'h1: s_nxt.hold_cam = {s_r.shreg[6:0], SDA_I};
                  2'h2: s_nxt.hold_aux = {s_r.shreg[6:0], SDA_I};
                  default: s_nxt.hold_aux = s_r.hold_aux;
                endcase
                if (s_r.byte_idx != 2'(`LLR_NUM_DATA_BYTES)) begin
                  s_nxt.byte_idx = s_r.byte_idx + 2'h1;
                end
                s_nxt.wrote = 1'b1;
              end
            end
          end
          llr_pkg::SER_IDLE,
          llr_pkg::SER_SKIP: begin
            s_nxt.bit_cnt = 3'h0;
          end
          default: begin
            s_nxt.ser_st = llr_pkg::SER_IDLE;
          end
        endcase
      end
      // Acknowledge slot: drive low for one clock
      if (scl_fall) begin
        if (s_r.pend_ack) begin
          s_nxt.pend_ack = 1'b0;
          s_nxt.in_ack = 1'b1;
          s_nxt.sda_oe = 1'b1;
        end else if (s_r.in_ack) begin
          s_nxt.in_ack = 1'b0;
          s_nxt.sda_oe = 1'b0;
        end
      end
    end

    // ----------------------------------------
    // Level load
    // ----------------------------------------
    // Transfer all holding registers at once, so levels never tear
    if (load_evt) begin
      s_nxt.act_pri = s_r.hold_pri; // [R14]
      s_nxt.act_cam = s_r.hold_cam;
      s_nxt.act_aux = s_r.hold_aux;
    end

    // ----------------------------------------
    // Camera select pin
    // ----------------------------------------
    // Two flops then a stability filter; a short spike never moves it
    s_nxt.cam_s1 = CAM_SEL_I; // [R18]
    s_nxt.cam_s2 = s_r.cam_s1;
    if (s_r.cam_s2 == s_r.cam_filt) begin
      s_nxt.filt_cnt = 2'h0;
    end else if (s_r.filt_cnt == 2'(`LLR_FILT_CYC)) begin
      s_nxt.cam_filt = s_r.cam_s2; // [R18]
      s_nxt.filt_cnt = 2'h0;
    end else begin
      s_nxt.filt_cnt = s_r.filt_cnt + 2'h1;
    end

    // ----------------------------------------
    // Pump mode
    // ----------------------------------------
    // Resets beat escalation; a held dropout steps only once
    s_nxt.drop_d = drop_now;
    if (load_evt || cam_fall) begin
      s_nxt.pump = llr_pkg::PUMP_1X; // [R10] [R16]
    end else if (drop_now && !s_r.drop_d) begin
      case (s_r.pump)
        llr_pkg::PUMP_1X: s_nxt.pump = llr_pkg::PUMP_1P5X; // [R15]
        llr_pkg::PUMP_1P5X: s_nxt.pump = llr_pkg::PUMP_2X; // [R15]
        llr_pkg::PUMP_2X: s_nxt.pump = llr_pkg::PUMP_2X;
        default: s_nxt.pump = llr_pkg::PUMP_1X;
      endcase
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    // Registered copies so every pin but SDA_O comes from a flop
    s_nxt.pri_lvl = s_r.act_pri; // [R1]
    s_nxt.pri_en = (s_r.act_pri != 8'h00); // [R2]
    s_nxt.cam_lvl = cam_sel_lvl;
    s_nxt.cam_en = (cam_sel_lvl != 4'h0); // [R11]
    s_nxt.aux_gpo_mode = s_r.act_aux[`LLR_AUX_GPO_MODE_BIT]; // [R4]
    s_nxt.aux_gpo = s_r.act_aux[`LLR_AUX_GPO_MODE_BIT] &
                    s_r.act_aux[`LLR_AUX_GPO_VAL_BIT]; // [R4]
    s_nxt.aux_lvl = s_r.act_aux[`LLR_AUX_GPO_MODE_BIT] ? `LLR_AUX_RST :
                    s_r.act_aux[`LLR_AUX_LVL_LSB +: 2]; // [R3]

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Answer in the first access cycle, ready is a one-cycle pulse
    s_nxt.pready = 1'b0;
    if (PSEL && !PENABLE) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = 1'b0;
      case (PADDR)
        `LLR_OFF_SLAVE_ADDR: s_nxt.prdata = {25'h0000000, s_r.slave_addr};
        `LLR_OFF_STATUS: s_nxt.prdata = status_word;
        `LLR_OFF_HOLD: s_nxt.prdata = hold_word;
        default: begin
          s_nxt.prdata = 32'h00000000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
      // Writes return no data; only the address register takes them
      if (PWRITE) begin
        s_nxt.prdata = 32'h00000000;
        s_nxt.pslverr = (PADDR != `LLR_OFF_SLAVE_ADDR);
      end
    end
    // Address register changes at the completing access edge only
    if (PSEL && PENABLE && s_r.pready && PWRITE && (PADDR == `LLR_OFF_SLAVE_ADDR)) begin
      s_nxt.slave_addr = PWDATA[6:0];
    end

    // ----------------------------------------
    // Undervoltage clear
    // ----------------------------------------
    // Clears every level-side register; the bus address survives
    if (UNDERVOLTAGE_LOCKOUT_I) begin
      s_nxt.ser_st = llr_pkg::SER_IDLE; // [R6]
      s_nxt.bit_cnt = 3'h0;
      s_nxt.shreg = 8'h00;
      s_nxt.byte_idx = 2'h0;
      s_nxt.pend_ack = 1'b0;
      s_nxt.in_ack = 1'b0;
      s_nxt.wrote = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.hold_pri = `LLR_PRI_RST; // [R6]
      s_nxt.hold_cam = 8'h00;
      s_nxt.hold_aux = 8'h00;
      s_nxt.act_pri = `LLR_PRI_RST;
      s_nxt.act_cam = 8'h00;
      s_nxt.act_aux = 8'h00;
      s_nxt.pump = llr_pkg::PUMP_1X;
      s_nxt.pri_lvl = `LLR_PRI_RST;
      s_nxt.pri_en = 1'b0;
      s_nxt.cam_lvl = `LLR_CAM_RST;
      s_nxt.cam_en = 1'b0;
      s_nxt.aux_lvl = `LLR_AUX_RST;
      s_nxt.aux_gpo = 1'b0;
      s_nxt.aux_gpo_mode = 1'b0;
      // Pin filter and dropout edge start over as well
      s_nxt.cam_s1 = 1'b0;
      s_nxt.cam_s2 = 1'b0;
      s_nxt.cam_filt = 1'b0;
      s_nxt.filt_cnt = 2'h0;
      s_nxt.drop_d = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_r <= '0; // [R17]
      s_r.slave_addr <= `LLR_SLAVE_ADDR_RST;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.pump <= llr_pkg::PUMP_1X; // [R17]
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all from state flops but the tied-low SDA_O
  // ----------------------------------------
  // Open-drain data pin: only the enable moves
  assign SDA_O = 1'b0;
  assign SDA_OE_O = s_r.sda_oe;

  // Level, enable and pump pins
  assign PRI_LEVEL_O = s_r.pri_lvl;
  assign PRI_EN_O = s_r.pri_en;
  assign CAM_LEVEL_O = s_r.cam_lvl;
  assign CAM_EN_O = s_r.cam_en;
  assign AUX_LEVEL_O = s_r.aux_lvl;
  assign AUX_GPO_O = s_r.aux_gpo;
  assign AUX_GPO_MODE_O = s_r.aux_gpo_mode;
  assign PUMP_MODE_O = 2'(s_r.pump);

  // Register bus answer
  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;

endmodule : llr_ctrl

`default_nettype wire

// [llr_defines.svh]
// Constants for the LED level register control block
`ifndef LLR_DEFINES_SVH
`define LLR_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LLR_OFF_SLAVE_ADDR 12'h000
`define LLR_OFF_STATUS 12'h004
`define LLR_OFF_HOLD 12'h008

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LLR_SLAVE_ADDR_RST 7'h1a
`define LLR_PRI_RST 8'h00
`define LLR_CAM_RST 4'h0
`define LLR_AUX_RST 2'h0

// ----------------------------------------
// Control byte field positions
// ----------------------------------------
`define LLR_AUX_LVL_LSB 0
`define LLR_AUX_GPO_MODE_BIT 2
`define LLR_AUX_GPO_VAL_BIT 3
`define LLR_CAM_SER_SEL_BIT 4
`define LLR_CAM_SER_OVR_BIT 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define LLR_CLK_NS 50
`define LLR_SPIKE_NS 50
`define LLR_FILT_CYC (((`LLR_SPIKE_NS) + (`LLR_CLK_NS) - 1) / (`LLR_CLK_NS))
`define LLR_NUM_DATA_BYTES 3

`endif

// [llr_host.sv]
// Serial host model writing level bytes to the block
`timescale 1ns/1ns
`default_nettype none
module llr_host (
  input wire logic clk_i,
  input wire logic oe_i,
  output logic scl_o,
  output wire logic sda_o
);
  logic drv;
  int acks;
  int hp = 3;
  // Pulled-up line, the device acknowledge pulls it low
  assign sda_o = drv & ~oe_i;
  initial begin
    scl_o = 1'b1;
    drv = 1'b1;
  end
  // One bit: data set while clock low, line sampled while high
  task automatic put(input logic b, output logic s);
    drv <= b;
    repeat (hp) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (hp) @(posedge clk_i);
    s = sda_o;
    scl_o <= 1'b0;
    repeat (hp) @(posedge clk_i);
  endtask : put
  // Start, address byte, three data bytes with ack slots, stop
  task automatic send(input logic [7:0] a, p, c, x);
    logic [31:0] w;
    logic s;
    w = {a, p, c, x};
    acks = 0;
    drv <= 1'b0;
    repeat (hp) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (hp) @(posedge clk_i);
    for (int i = 31; i >= 0; i--) begin
      put(w[i], s);
      if (i % 8 == 0) begin
        put(1'b1, s);
        acks += (s === 1'b0);
      end
    end
    drv <= 1'b0;
    repeat (hp) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (hp) @(posedge clk_i);
    drv <= 1'b1;
    repeat (hp) @(posedge clk_i);
  endtask : send
endmodule : llr_host
`default_nettype wire

// [llr_pkg.sv]
// Types for the LED level register control block
`default_nettype none
package llr_pkg;

  // Serial receive states
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_ADDR,
    SER_DATA,
    SER_SKIP
  } llr_ser_st_t;

  // Charge pump modes
  typedef enum logic [1:0] {
    PUMP_1X,
    PUMP_1P5X,
    PUMP_2X
  } llr_pump_t;

  // Whole state of the block
  typedef struct packed {
    llr_ser_st_t ser_st;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] byte_idx;
    logic pend_ack;
    logic in_ack;
    logic wrote;
    logic scl_d;
    logic sda_d;
    logic sda_oe;
    logic [7:0] hold_pri;
    logic [7:0] hold_cam;
    logic [7:0] hold_aux;
    logic [7:0] act_pri;
    logic [7:0] act_cam;
    logic [7:0] act_aux;
    logic cam_s1;
    logic cam_s2;
    logic cam_filt;
    logic [1:0] filt_cnt;
    llr_pump_t pump;
    logic drop_d;
    logic [6:0] slave_addr;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] pri_lvl;
    logic pri_en;
    logic [3:0] cam_lvl;
    logic cam_en;
    logic [1:0] aux_lvl;
    logic aux_gpo;
    logic aux_gpo_mode;
  } llr_state_t;

endpackage : llr_pkg

`default_nettype wire

// [llr_props.sv]
// Concurrent checks on the ports of the LED level register control block
`timescale 1ns/1ns
`default_nettype none
module llr_props (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic UNDERVOLTAGE_LOCKOUT_I,
  input wire logic SCL_I,
  input wire logic CAM_SEL_I,
  input wire logic PRI_DROPOUT_I,
  input wire logic CAM_DROPOUT_I,
  input wire logic SDA_OE_O,
  input wire logic [7:0] PRI_LEVEL_O,
  input wire logic PRI_EN_O,
  input wire logic [3:0] CAM_LEVEL_O,
  input wire logic CAM_EN_O,
  input wire logic [1:0] PUMP_MODE_O,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_pri_off:
    assert property (PRI_EN_O == (PRI_LEVEL_O != 8'h00)) else $error("primary enable wrong");
  a_cam_off:
    assert property (CAM_EN_O == (CAM_LEVEL_O != 4'h0)) else $error("camera enable wrong");
  a_undervoltage_lockout_clear:
    assert property (UNDERVOLTAGE_LOCKOUT_I |=> PRI_LEVEL_O == 8'h00 && CAM_LEVEL_O == 4'h0
      && PUMP_MODE_O == 2'h0) else $error("undervoltage did not clear");
  a_reset_clear:
    assert property (disable iff (1'b0) RESET_I |=> PRI_LEVEL_O == 8'h00
      && PUMP_MODE_O == 2'h0) else $error("reset did not clear");
  a_pump_step:
    assert property (PUMP_MODE_O != $past(PUMP_MODE_O) && PUMP_MODE_O != 2'h0
      |-> PUMP_MODE_O == $past(PUMP_MODE_O) + 2'h1) else $error("pump skipped a step");
  a_pump_cause:
    assert property (PUMP_MODE_O > $past(PUMP_MODE_O) |-> $past(PRI_DROPOUT_I)
      || $past(CAM_DROPOUT_I)) else $error("pump rose without dropout");
  a_sel_fall:
    assert property ($fell(CAM_SEL_I) ##1 !CAM_SEL_I [*5] |-> ##[0:3] PUMP_MODE_O == 2'h0)
      else $error("select fall kept pump mode");
  a_ack_low:
    assert property ($rose(SDA_OE_O) |-> !SCL_I && !$past(SCL_I)) else $error("ack off slot");
  a_apb_ready:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready in access");
  a_ready_pulse:
    assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
endmodule : llr_props
`default_nettype wire

// [llr_tb.sv]
// Self-checking testbench for the LED level register control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic CLK_I, RESET_I, UNDERVOLTAGE_LOCKOUT_I, CAM_SEL_I, PRI_DROPOUT_I, CAM_DROPOUT_I;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SDA_OE_O, SCL_I, SDA_I, er;
  logic PRI_EN_O, CAM_EN_O, AUX_GPO_O, AUX_GPO_MODE_O;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [7:0] PRI_LEVEL_O;
  logic [3:0] CAM_LEVEL_O;
  logic [1:0] AUX_LEVEL_O, PUMP_MODE_O;
  int errors, checked, cyc, seed, pri, hi, lo, ctl, sa;
  llr_ctrl i_dut (.CLK_I, .RESET_I, .UNDERVOLTAGE_LOCKOUT_I, .SCL_I, .SDA_I, .SDA_O(), .SDA_OE_O,
    .CAM_SEL_I, .PRI_DROPOUT_I, .CAM_DROPOUT_I, .PRI_LEVEL_O, .PRI_EN_O, .CAM_LEVEL_O,
    .CAM_EN_O, .AUX_LEVEL_O, .AUX_GPO_O, .AUX_GPO_MODE_O, .PUMP_MODE_O, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  llr_host i_host (.clk_i(CLK_I), .oe_i(SDA_OE_O), .scl_o(SCL_I), .sda_o(SDA_I));
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task summarize;
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // One APB transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_I);
    PENABLE <= 1'b1;
    do @(posedge CLK_I); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // Outputs against the level model
  task verify;
    logic s;
    s = ctl[5] ? ctl[4] : CAM_SEL_I;
    chk("pri", PRI_LEVEL_O, pri);
    chk("pri_en", PRI_EN_O, pri != 0);
    chk("cam", CAM_LEVEL_O, s ? hi : lo);
    chk("cam_en", CAM_EN_O, (s ? hi : lo) != 0);
    chk("aux", {AUX_GPO_O, AUX_GPO_MODE_O, AUX_LEVEL_O}, ctl[2] ? ctl & 12 : ctl & 3);
  endtask : verify
  // Serial write, model takes it only at the right address
  task load(input int p, h, l, c, a);
    i_host.send({a[6:0], 1'b0}, p[7:0], {h[3:0], l[3:0]}, c[7:0]);
    if (a == sa) begin
      pri = p[7:0];
      hi = h[3:0];
      lo = l[3:0];
      ctl = c[7:0];
    end
    repeat (4) @(posedge CLK_I);
    chk("acks", i_host.acks, a == sa ? 4 : 0);
    verify();
  endtask : load
  task drop(input logic [1:0] m);
    {CAM_DROPOUT_I, PRI_DROPOUT_I} <= m;
    repeat (4) @(posedge CLK_I);
    {CAM_DROPOUT_I, PRI_DROPOUT_I} <= 2'h0;
    repeat (4) @(posedge CLK_I);
  endtask : drop
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {seed, pri, hi, lo, ctl, sa} = {32'd43, 128'h0, 32'h1a};
    {RESET_I, UNDERVOLTAGE_LOCKOUT_I, CAM_SEL_I, PRI_DROPOUT_I, CAM_DROPOUT_I} = 5'h10;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    repeat (12) @(posedge CLK_I);
    RESET_I <= 1'b0;
    verify();
    chk("pump", PUMP_MODE_O, 0);
    apb(1'b0, 12'h000, 32'h0);
    chk("addr", rd, 32'h1a);
    apb(1'b1, 12'h004, 32'h1);
    chk("ro_err", er, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("map_err", er, 1'b1);
    sa = $random(seed) & 32'h7f;
    apb(1'b1, 12'h000, sa);
    apb(1'b0, 12'h000, 32'h0);
    chk("addr", rd, sa);
    load(0, 9, 0, 32'h20, sa);
    load(1, 9, 0, 32'h0, sa);
    for (int i = 0; i < 8; i++) begin
      CAM_SEL_I <= i[0];
      i_host.hp = i[0] ? 6 : 3;
      load($random(seed), $random(seed), $random(seed), $random(seed) & 32'h3f,
        i == 5 ? sa ^ 1 : sa);
    end
    load(32'h40, 1, 2, 0, sa);
    drop(2'h1);
    chk("pump", PUMP_MODE_O, 1);
    drop(2'h2);
    chk("pump", PUMP_MODE_O, 2);
    load(32'h40, 1, 2, 0, sa);
    chk("pump", PUMP_MODE_O, 0);
    drop(2'h1);
    chk("pump", PUMP_MODE_O, 1);
    // One-cycle dip on the select pin must be filtered out
    CAM_SEL_I <= 1'b0;
    @(posedge CLK_I);
    CAM_SEL_I <= 1'b1;
    repeat (12) @(posedge CLK_I);
    chk("pump", PUMP_MODE_O, 1);
    CAM_SEL_I <= 1'b0;
    repeat (12) @(posedge CLK_I);
    chk("pump", PUMP_MODE_O, 0);
    verify();
    // Readback: supply good, pin low, no override, pump back at 1x
    apb(1'b0, 12'h004, 32'h0);
    chk("status", rd, {12'h000, 2'h0, ctl[1:0], hi[3:0], lo[3:0], pri[7:0]});
    apb(1'b0, 12'h008, 32'h0);
    chk("hold", rd, {8'h00, ctl[7:0], hi[3:0], lo[3:0], pri[7:0]});
    UNDERVOLTAGE_LOCKOUT_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    {pri, hi, lo, ctl} = '0;
    verify();
    UNDERVOLTAGE_LOCKOUT_I <= 1'b0;
    summarize();
  end
endmodule : testbench
bind llr_ctrl llr_props i_props (.CLK_I, .RESET_I, .UNDERVOLTAGE_LOCKOUT_I, .SCL_I, .CAM_SEL_I,
  .PRI_DROPOUT_I, .CAM_DROPOUT_I, .SDA_OE_O, .PRI_LEVEL_O, .PRI_EN_O, .CAM_LEVEL_O,
  .CAM_EN_O, .PUMP_MODE_O, .PSEL, .PENABLE, .PREADY);
`default_nettype wire
